// *** logic/rpp_pkg.sv ***
// package of constants and types for the rx port register paging block
// What this block does
// - Every access to the per-port ranges is steered by the page-select register of its source.
// - Bits 5:4 of the page select pick the one port block returned on reads, 00 to 11 for port 0 to 3.
// - Bits 3:0 are per-port write enables and a paged write, except to the first status register, reaches every enabled block at once.
// - Each access source keeps its own page-select state, untouched by other sources.
// - Bits 7:6 of the page select read 0 locally and the carrying port number over the channel.
// - The read-port field resets to 0 locally and to the carrying port for channel sources.
// - Write enables reset to 0 locally, and the carrying port's enable resets to 1 for channel sources.
// - The first port status register is paged and reads show the selected port's contents.
// - Status bits 7:6 are read-only and report the selected read port number.
// - Status bit 5 sets on a forward channel CRC error and clears when the register is read.
// - Status bit 4 sets on any lock change since the last read and clears on read.
// - With enhanced reporting off, status bit 3 flags a sequence error and clears on read.
// - With enhanced reporting on, bit 3 flags any channel error and clears on a detail status read.
// - Status bit 0 shows the present lock state of the selected receiver.
package rpp_pkg;
   localparam int NUM_PORTS = 4;
   localparam int NUM_SRC = 6; // two local ports, then one channel source per rx port
   localparam int FIRST_CHAN_SRC = 2;
   // register offsets
   localparam logic [7:0] ADDR_PAGE_SEL = 8'h4c;
   localparam logic [7:0] ADDR_STATUS_FIRST = 8'h4d;
   localparam logic [7:0] PAGED_LO_A = 8'h4d;
   localparam logic [7:0] PAGED_HI_A = 8'h7f;
   localparam logic [7:0] PAGED_LO_B = 8'hd0;
   localparam logic [7:0] PAGED_HI_B = 8'hdf;
   // page select fields
   localparam int PHYS_MSB = 7;
   localparam int PHYS_LSB = 6;
   localparam int RDPORT_MSB = 5;
   localparam int RDPORT_LSB = 4;
   localparam int WREN_MSB = 3;
   localparam int WREN_LSB = 0;
   localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
   // status fields
   localparam int STS_PORT_MSB = 7;
   localparam int STS_PORT_LSB = 6;
   localparam int STS_CRC_BIT = 5;
   localparam int STS_LOCKCHG_BIT = 4;
   localparam int STS_SEQ_BIT = 3;
   localparam int STS_LOCK_BIT = 0;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // answer latency for a read, in ref_clk cycles
   localparam int READ_LATENCY = 1;
   typedef logic [1:0] rpp_port_t;
   typedef logic [2:0] rpp_src_t;
endpackage

// *** logic/rpp_port_paging.sv ***
// paged register access and first port status register for a four-port receiver hub
module rpp_port_paging
   import rpp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic linkClk,
   input wire logic linkRstN,
   // register access from the local i2c ports and the control channel
   input wire logic accValid,
   input wire logic accWrite,
   input wire rpp_src_t accSrc,
   input wire logic [7:0] accAddr,
   input wire logic [7:0] accWdata,
   output logic accRdValid,
   output logic [7:0] accRdata,
   // paged register blocks outside this module
   output logic [3:0] pageWrEn,
   output logic [7:0] pageWrAddr,
   output logic [7:0] pageWrData,
   output rpp_port_t pageRdPort,
   output logic [7:0] pageRdAddr,
   input wire logic [31:0] pageRdData,
   // error reporting control, ref_clk domain
   input wire logic enhanced_error_enable,
   input wire logic [3:0] ctrlChannelErrorDetailRead,
   // receiver events, link clock domain
   input wire logic [3:0] receiver_lock_state,
   input wire logic [3:0] ctrlChannelCrcErr,
   input wire logic [3:0] ctrlChannelSeqErr
);

   // is the address inside one of the per-port ranges
   function automatic logic isPaged(input logic [7:0] a);
      isPaged = ((a >= PAGED_LO_A) && (a <= PAGED_HI_A)) || ((a >= PAGED_LO_B) && (a <= PAGED_HI_B));
   endfunction

   // carrying port of a source, 0 for local sources
   function automatic rpp_port_t physPort(input rpp_src_t s);
      if (s >= rpp_src_t'(FIRST_CHAN_SRC)) begin
         physPort = rpp_port_t'(s - rpp_src_t'(FIRST_CHAN_SRC));
      end else begin
         physPort = 2'h0;
      end
   endfunction

   // ---------------- link clock domain ----------------
   logic [3:0] lnkLock_q;
   logic [3:0] lnkCrcTog_q;
   logic [3:0] lnkSeqTog_q;

   // lock level registered on the link clock before crossing
   always_ff @(posedge linkClk) begin
      if (!linkRstN) begin
         lnkLock_q <= 4'h0;
      end else begin
         lnkLock_q <= receiver_lock_state;
      end
   end

   // crc error pulses turned into toggles, a pulse is too short to cross directly
   always_ff @(posedge linkClk) begin
      if (!linkRstN) begin
         lnkCrcTog_q <= 4'h0;
      end else begin
         lnkCrcTog_q <= lnkCrcTog_q ^ ctrlChannelCrcErr;
      end
   end

   // sequence error pulses turned into toggles the same way
   always_ff @(posedge linkClk) begin
      if (!linkRstN) begin
         lnkSeqTog_q <= 4'h0;
      end else begin
         lnkSeqTog_q <= lnkSeqTog_q ^ ctrlChannelSeqErr;
      end
   end

   // ---------------- crossing into ref_clk ----------------
   logic [3:0] lockMeta_q;
   logic [3:0] lockSync_q;
   logic [3:0] lockPrev_q;
   logic [3:0] crcMeta_q;
   logic [3:0] crcSync_q;
   logic [3:0] crcPrev_q;
   logic [3:0] seqMeta_q;
   logic [3:0] seqSync_q;
   logic [3:0] seqPrev_q;

   // each bit crosses on its own: lock bits are slow levels and events are toggles
   // lock level: two flip-flop synchroniser, then one stage kept for edge detection
   // a port already locked at reset release shows one lock change from the reset state
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         lockMeta_q <= 4'h0;
         lockSync_q <= 4'h0;
         lockPrev_q <= 4'h0;
      end else begin
         lockMeta_q <= lnkLock_q;
         lockSync_q <= lockMeta_q;
         lockPrev_q <= lockSync_q;
      end
   end

   // crc toggle: same synchroniser, each toggle edge marks one event
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         crcMeta_q <= 4'h0;
         crcSync_q <= 4'h0;
         crcPrev_q <= 4'h0;
      end else begin
         crcMeta_q <= lnkCrcTog_q;
         crcSync_q <= crcMeta_q;
         crcPrev_q <= crcSync_q;
      end
   end

   // sequence toggle: same synchroniser, each toggle edge marks one event
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         seqMeta_q <= 4'h0;
         seqSync_q <= 4'h0;
         seqPrev_q <= 4'h0;
      end else begin
         seqMeta_q <= lnkSeqTog_q;
         seqSync_q <= seqMeta_q;
         seqPrev_q <= seqSync_q;
      end
   end

   logic [3:0] lockChgEvt;
   logic [3:0] crcEvt;
   logic [3:0] seqEvt;

   // one-cycle events per port in the ref_clk domain
   assign lockChgEvt = lockSync_q ^ lockPrev_q;
   assign crcEvt = crcSync_q ^ crcPrev_q;
   assign seqEvt = seqSync_q ^ seqPrev_q;

   // ---------------- page select state per source ----------------
   // sources 0 and 1 are the local i2c ports, 2 to 5 the channel over rx port 0 to 3
   logic [NUM_SRC-1:0][1:0] rdPort_q;
   logic [NUM_SRC-1:0][3:0] wrEn_q;
   logic [7:0] pageSelWr;
   rpp_port_t curRdPort;
   logic [3:0] curWrEn;
   logic isRead;
   logic isWrite;

   assign isRead = accValid && !accWrite;
   assign isWrite = accValid && accWrite;

   // illegal sources 6 and 7 see port 0 with writes disabled rather than unknowns
   always_comb begin
      curRdPort = 2'h0;
      curWrEn = 4'h0;
      if (int'(accSrc) < NUM_SRC) begin
         curRdPort = rdPort_q[accSrc];
         curWrEn = wrEn_q[accSrc];
      end
   end

   assign pageSelWr = accWdata;

   // per-source paging registers with source-dependent reset values
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         for (int s = 0; s < NUM_SRC; s++) begin
            if (s >= FIRST_CHAN_SRC) begin
               rdPort_q[s] <= rpp_port_t'(s - FIRST_CHAN_SRC);
               wrEn_q[s] <= 4'h1 << (s - FIRST_CHAN_SRC);
            end else begin
               rdPort_q[s] <= PAGE_SEL_RESET[RDPORT_MSB:RDPORT_LSB];
               wrEn_q[s] <= PAGE_SEL_RESET[WREN_MSB:WREN_LSB];
            end
         end
      end else if (isWrite && (accAddr == ADDR_PAGE_SEL) && (int'(accSrc) < NUM_SRC)) begin
         rdPort_q[accSrc] <= pageSelWr[RDPORT_MSB:RDPORT_LSB];
         wrEn_q[accSrc] <= pageSelWr[WREN_MSB:WREN_LSB];
      end
   end

   // ---------------- paged writes to external blocks ----------------
   // one-cycle write strobe per enabled port, registered
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         pageWrEn <= 4'h0;
      end else if (isWrite && isPaged(accAddr) && (accAddr != ADDR_STATUS_FIRST)) begin
         pageWrEn <= curWrEn;
      end else begin
         pageWrEn <= 4'h0;
      end
   end

   // address and data of the last access, only meaningful with the strobe above
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         pageWrAddr <= 8'h00;
         pageWrData <= 8'h00;
      end else begin
         pageWrAddr <= accAddr;
         pageWrData <= accWdata;
      end
   end

   // read port offered to the external blocks follows the requesting source
   // the external blocks answer in the request cycle, the data is registered below
   assign pageRdPort = curRdPort;
   assign pageRdAddr = accAddr;

   // ---------------- first port status register, per port ----------------
   logic [3:0] crcFlag_q;
   logic [3:0] lockChgFlag_q;
   logic [3:0] seqFlag_q;
   logic [3:0] errSumFlag_q;
   logic [3:0] stsReadClr;

   // a status read clears the flags of the selected port only
   // flags of the other ports survive, so each event is seen at least once
   always_comb begin
      stsReadClr = 4'h0;
      if (isRead && (accAddr == ADDR_STATUS_FIRST)) begin
         stsReadClr[curRdPort] = 1'b1;
      end
   end

   // crc flag per port, a new event wins over a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         crcFlag_q <= STATUS_RESET[NUM_PORTS-1:0];
      end else begin
         crcFlag_q <= crcEvt | (crcFlag_q & ~stsReadClr);
      end
   end

   // lock change flag per port, cleared by a status read of that port
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         lockChgFlag_q <= STATUS_RESET[NUM_PORTS-1:0];
      end else begin
         lockChgFlag_q <= lockChgEvt | (lockChgFlag_q & ~stsReadClr);
      end
   end

   // sequence flag per port, kept in both modes so a mode switch loses nothing
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         seqFlag_q <= STATUS_RESET[NUM_PORTS-1:0];
      end else begin
         seqFlag_q <= seqEvt | (seqFlag_q & ~stsReadClr);
      end
   end

   // error summary per port, only a detail status read clears it
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         errSumFlag_q <= STATUS_RESET[NUM_PORTS-1:0];
      end else begin
         errSumFlag_q <= crcEvt | seqEvt | (errSumFlag_q & ~ctrlChannelErrorDetailRead);
      end
   end

   logic [7:0] stsValue;
   logic [7:0] pageSelValue;

   // read image of the status register for the selected port
   always_comb begin
      stsValue = 8'h00;
      stsValue[STS_PORT_MSB:STS_PORT_LSB] = curRdPort;
      stsValue[STS_CRC_BIT] = crcFlag_q[curRdPort];
      stsValue[STS_LOCKCHG_BIT] = lockChgFlag_q[curRdPort];
      if (enhanced_error_enable) begin
         stsValue[STS_SEQ_BIT] = errSumFlag_q[curRdPort];
      end else begin
         stsValue[STS_SEQ_BIT] = seqFlag_q[curRdPort];
      end
      stsValue[STS_LOCK_BIT] = lockSync_q[curRdPort];
   end

   // read image of the page select register for the requesting source
   always_comb begin
      pageSelValue = 8'h00;
      pageSelValue[PHYS_MSB:PHYS_LSB] = physPort(accSrc);
      pageSelValue[RDPORT_MSB:RDPORT_LSB] = curRdPort;
      pageSelValue[WREN_MSB:WREN_LSB] = curWrEn;
   end

   // ---------------- read answer ----------------
   // read strobe one cycle after the request
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         accRdValid <= 1'b0;
      end else begin
         accRdValid <= isRead;
      end
   end

   // read data held until the next read, unmapped offsets read zero
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         accRdata <= 8'h00;
      end else if (!isRead) begin
         accRdata <= accRdata;
      end else if (accAddr == ADDR_PAGE_SEL) begin
         accRdata <= pageSelValue;
      end else if (accAddr == ADDR_STATUS_FIRST) begin
         accRdata <= stsValue;
      end else if (isPaged(accAddr)) begin
         accRdata <= pageRdData[curRdPort*8 +: 8];
      end else begin
         accRdata <= 8'h00;
      end
   end

endmodule // rpp_port_paging

// *** dv/rpp_port_paging_chk.sv ***
// concurrent checks on the ports of the paging block
module rpp_port_paging_chk
   import rpp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic accValid,
   input wire logic accWrite,
   input wire rpp_src_t accSrc,
   input wire logic [7:0] accAddr,
   input wire logic [7:0] accWdata,
   input wire logic accRdValid,
   input wire logic [7:0] accRdata,
   input wire logic [3:0] pageWrEn,
   input wire logic [7:0] pageWrAddr,
   input wire logic [7:0] pageWrData,
   input wire rpp_port_t pageRdPort,
   input wire logic [31:0] pageRdData
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   logic rdReq;
   logic paged;
   // request decode
   assign rdReq = accValid && !accWrite;
   assign paged = (accAddr > ADDR_STATUS_FIRST && accAddr <= PAGED_HI_A) ||
      (accAddr >= PAGED_LO_B && accAddr <= PAGED_HI_B);
   AST_RD_ANSWER: assert property (rdReq |=> accRdValid)
      else $error("read not answered");
   AST_RD_CAUSE: assert property (accRdValid |-> $past(rdReq))
      else $error("read answer without request");
   AST_WR_PAGE: assert property (pageWrEn != 4'h0 |-> $past(accValid && accWrite && paged)
      && pageWrAddr == $past(accAddr) && pageWrData == $past(accWdata))
      else $error("paged write not from a paged write request");
   AST_WR_UNPAGED: assert property (accValid && accWrite && !paged |=> pageWrEn == 4'h0)
      else $error("unpaged write reached port blocks");
   AST_PHYS_LOCAL: assert property (rdReq && accAddr == ADDR_PAGE_SEL && accSrc < 3'h2
      |=> accRdata[PHYS_MSB:PHYS_LSB] == 2'h0) else $error("local port number not zero");
   AST_PHYS_CHAN: assert property (rdReq && accAddr == ADDR_PAGE_SEL && accSrc >= 3'h2
      |=> accRdata[7:6] == $past(accSrc[1:0] ^ 2'h2)) else $error("channel port number wrong");
   AST_STS_PORT: assert property (rdReq && accAddr <= ADDR_STATUS_FIRST && accAddr >= 8'h4c
      |=> ($past(accAddr == ADDR_STATUS_FIRST) ? accRdata[7:6] : accRdata[5:4])
         == $past(pageRdPort))
      else $error("read port field wrong");
   AST_PAGED_RD: assert property (rdReq && paged
      |=> accRdata == $past(pageRdData[{pageRdPort, 3'h0} +: 8]))
      else $error("paged read from wrong port");
endmodule // rpp_port_paging_chk
bind rpp_port_paging rpp_port_paging_chk rpp_port_paging_chk_i (.ref_clk, .nrst, .accValid,
   .accWrite, .accSrc, .accAddr, .accWdata, .accRdValid, .accRdata, .pageWrEn, .pageWrAddr,
   .pageWrData, .pageRdPort, .pageRdData);

// *** dv/rpp_link_model.sv ***
// link side model making lock and control channel error events
module rpp_link_model (
   input wire logic linkClk,
   output logic [3:0] lockState,
   output logic [3:0] crcErr,
   output logic [3:0] seqErr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      lockState = 4'h0;
      crcErr = 4'h0;
      seqErr = 4'h0;
   end
   // one event: 0 crc pulse, 1 sequence pulse, else lock toggle; then settle
   task automatic ev(input int kind, input int port);
      @(posedge linkClk);
      case (kind)
         0: crcErr[port] <= 1'h1;
         1: seqErr[port] <= 1'h1;
         default: lockState[port] <= ~lockState[port];
      endcase
      @(posedge linkClk);
      crcErr <= 4'h0;
      seqErr <= 4'h0;
      repeat (8) @(posedge linkClk); // spacing and sync delay
   endtask
endmodule // rpp_link_model

// *** dv/tb_rx_port_register_paging.sv ***
// testbench for the rx port register paging block
module tb_rx_port_register_paging import rpp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'h0, linkClk = 1'h0, nrst = 1'h0, linkRstN = 1'h0;
   logic accValid = 1'h0, accWrite = 1'h0, eeEn = 1'h0, accRdValid;
   rpp_src_t accSrc = 3'h0;
   rpp_port_t pageRdPort;
   logic [7:0] accAddr = 8'h0, accWdata = 8'h0, accRdata, pageWrAddr, pageWrData, pageRdAddr;
   logic [3:0] detRd = 4'h0, pageWrEn, lockSt, crcErr, seqErr;
   logic [31:0] pageRdData;
   int n_mismatch = 0, total_checks = 0;
   // clocks, link clock offset so rising edges never meet
   always #5 ref_clk = ~ref_clk;
   initial begin
      #2;
      forever #6 linkClk = ~linkClk;
   end
   // port blocks: byte n is 0x10*n xor the address
   assign pageRdData = 32'h30201000 ^ {4{pageRdAddr}};
   rpp_port_paging rpp_port_paging_i (.ref_clk, .nrst, .linkClk, .linkRstN, .accValid, .accWrite,
      .accSrc, .accAddr, .accWdata, .accRdValid, .accRdata, .pageWrEn, .pageWrAddr, .pageWrData,
      .pageRdPort, .pageRdAddr, .pageRdData, .enhanced_error_enable(eeEn),
      .ctrlChannelErrorDetailRead(detRd), .receiver_lock_state(lockSt),
      .ctrlChannelCrcErr(crcErr), .ctrlChannelSeqErr(seqErr));
   rpp_link_model rpp_link_model_i (.linkClk, .lockState(lockSt), .crcErr, .seqErr);
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one access, returns just after the answer edge
   task automatic acc(input int s, input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      accValid <= 1'h1;
      accSrc <= rpp_src_t'(s);
      accWrite <= w;
      accAddr <= a;
      accWdata <= d;
      @(posedge ref_clk);
      accValid <= 1'h0;
      #1;
   endtask
   task automatic rd(input int s, input logic [7:0] a, input logic [7:0] exp);
      acc(s, 1'h0, a, 8'h0);
      cmp("read valid", 8'h01, {7'h0, accRdValid});
      cmp("read data", exp, accRdata);
   endtask
   task automatic t_reset;
      for (int k = 0; k < 6; k++) begin
         rd(k, ADDR_PAGE_SEL, k < 2 ? 8'h0 : 8'((k - 2) * 8'h50 | (1 << (k - 2))));
      end
      $display("test reset values done");
   endtask
   task automatic t_paging;
      for (int p = 0; p < 4; p++) begin
         acc(0, 1'h1, ADDR_PAGE_SEL, 8'(p << 4));
         rd(0, PAGED_LO_B, 8'(p * 16) ^ PAGED_LO_B);
      end
      acc(0, 1'h1, ADDR_PAGE_SEL, 8'hf5);
      rd(0, ADDR_PAGE_SEL, 8'h35);
      rd(1, ADDR_PAGE_SEL, 8'h00);
      rd(2, ADDR_PAGE_SEL, 8'h01);
      rd(0, PAGED_HI_A, 8'h30 ^ PAGED_HI_A);
      acc(0, 1'h1, 8'h60, 8'ha5);
      cmp("write enables", 8'h05, {4'h0, pageWrEn});
      cmp("write addr", 8'h60, pageWrAddr);
      cmp("write data", 8'ha5, pageWrData);
      acc(1, 1'h1, 8'h60, 8'h5a);
      cmp("write enables", 8'h00, {4'h0, pageWrEn});
      acc(0, 1'h1, ADDR_STATUS_FIRST, 8'hff);
      cmp("write enables", 8'h00, {4'h0, pageWrEn});
      rd(0, 8'h20, 8'h00);
      $display("test paging done");
   endtask
   task automatic t_status;
      acc(0, 1'h1, ADDR_PAGE_SEL, 8'h20);
      rpp_link_model_i.ev(2, 2);
      rpp_link_model_i.ev(0, 2);
      rd(0, ADDR_STATUS_FIRST, 8'hb1);
      rd(0, ADDR_STATUS_FIRST, 8'h81);
      rpp_link_model_i.ev(0, 1);
      rd(0, ADDR_STATUS_FIRST, 8'h81);
      acc(0, 1'h1, ADDR_PAGE_SEL, 8'h10);
      rd(0, ADDR_STATUS_FIRST, 8'h60);
      acc(0, 1'h1, ADDR_PAGE_SEL, 8'h20);
      rpp_link_model_i.ev(1, 2);
      rd(0, ADDR_STATUS_FIRST, 8'h89);
      rd(0, ADDR_STATUS_FIRST, 8'h81);
      $display("test status flags done");
   endtask
   task automatic t_enhanced;
      @(posedge ref_clk);
      eeEn <= 1'h1;
      detRd <= 4'h4;
      @(posedge ref_clk);
      detRd <= 4'h0;
      repeat (2) @(posedge ref_clk);
      rd(0, ADDR_STATUS_FIRST, 8'h81);
      rpp_link_model_i.ev(1, 2);
      rd(0, ADDR_STATUS_FIRST, 8'h89);
      rd(0, ADDR_STATUS_FIRST, 8'h89);
      @(posedge ref_clk);
      detRd <= 4'h4;
      @(posedge ref_clk);
      detRd <= 4'h0;
      repeat (2) @(posedge ref_clk);
      rd(0, ADDR_STATUS_FIRST, 8'h81);
      $display("test enhanced errors done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // link domain reset
   initial begin
      repeat (2) @(posedge linkClk);
      linkRstN <= 1'h1;
   end
   // main sequence
   initial begin
      repeat (2) @(posedge ref_clk);
      nrst <= 1'h1;
      t_reset();
      t_paging();
      t_status();
      t_enhanced();
      wrap_up();
   end
   // watchdog, far beyond the roughly 140 ref_clk cycles the tests need
   initial begin
      #50us;
      n_mismatch++;
      $display("watchdog expired");
      wrap_up();
   end
endmodule // tb_rx_port_register_paging
